// File: logic/mag_status_pkg.sv
package mag_status_pkg;
  // Register indices; the printed offsets are not word multiples, byte address = 4 * index
  localparam logic [7:0] STATUS_IDX = 8'h32;
  localparam logic [7:0] X_HI_IDX = 8'h33;
  localparam logic [7:0] X_LO_IDX = 8'h34;
  localparam logic [7:0] Y_HI_IDX = 8'h35;
  localparam logic [7:0] Y_LO_IDX = 8'h36;
  localparam logic [7:0] Z_HI_IDX = 8'h37;
  localparam logic [7:0] Z_LO_IDX = 8'h38;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h40;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h41;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // Status bit positions
  localparam int X_READY_BIT = 0;
  localparam int Y_READY_BIT = 1;
  localparam int Z_READY_BIT = 2;
  localparam int ALL_READY_BIT = 3;
  localparam int X_OVR_BIT = 4;
  localparam int Y_OVR_BIT = 5;
  localparam int Z_OVR_BIT = 6;
  localparam int ALL_OVR_BIT = 7;
  localparam int AXES = 3;
  // Interrupt event bits: new data per axis, any overrun
  localparam int IRQ_BITS = 4;
endpackage : mag_status_pkg

// File: logic/mag_sample_store.sv
`timescale 1ns/10ps
// Holds one 16-bit sample per axis; read data registered
module mag_sample_store (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Async reset, high
  input wire logic [2:0] wr_en, // Per-axis sample write
  input wire logic [47:0] wr_data, // Samples, X in low half-word
  input wire logic [1:0] rd_axis, // Axis to read
  input wire logic rd_hi, // High byte when set
  output logic [7:0] rd_data // Registered byte
);
  import mag_status_pkg::*;
  logic [15:0] mem_reg [AXES];
  logic [15:0] mem_next [AXES];
  logic [7:0] rd_data_next;

  always_comb begin
    for (int i = 0; i < AXES; i++) begin
      mem_next[i] = wr_en[i] ? wr_data[16*i +: 16] : mem_reg[i];
    end
    rd_data_next = 8'h00;
    if (rd_axis < 2'(AXES)) begin
      rd_data_next = rd_hi ? mem_reg[rd_axis][15:8] : mem_reg[rd_axis][7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < AXES; i++) begin
        mem_reg[i] <= SAMPLE_RESET;
      end
      rd_data <= 8'h00;
    end else begin
      mem_reg <= mem_next;
      rd_data <= rd_data_next;
    end
  end
endmodule : mag_sample_store

// File: logic/mag_ready_status.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// R1: x_overrun shows 1 if an unread X sample was overwritten, else 0.
// R2: all_axes_ready goes 1 when a fresh X, Y and Z set exists.
// R3: all_axes_ready clears only after all three high bytes are read.
// R4: z_ready sets on each completed Z acquisition.
// R5: Reading the Z high byte clears z_ready.
// R6: y_ready sets on each completed Y acquisition.
// R7: Reading the Y high byte clears y_ready.
// R8: x_ready sets on each completed X acquisition.
// R9: Reading the X high byte clears x_ready.
// R10: x_overrun sets on new X before old X read; X high-byte read clears.
// R11: all_axes_overrun sets on any overwrite; clears after all high bytes read.
// R12: Each axis sample is 16-bit two's complement in high and low byte.
// R13: Writes to the status register change nothing.
module mag_ready_status (
  input wire logic clk, // 200 MHz clock
  input wire logic sys_rst, // Async reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [2:0] sample_done, // Per-axis acquisition done pulse, X bit 0
  input wire logic [47:0] sample_data, // New samples, X in [15:0]
  output logic [7:0] status_out, // Flag byte mirror
  output logic irq // Level interrupt
);
  import mag_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
  endfunction : hit

  logic access, setup, rd_x_hi, rd_y_hi, rd_z_hi, rd_stat, rd_irq;
  logic [2:0] hi_read;
  // Sample-byte access takes three cycles: data read path is registered in the store
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign rd_x_hi = access && !pwrite && hit(paddr, X_HI_IDX);
  assign rd_y_hi = access && !pwrite && hit(paddr, Y_HI_IDX);
  assign rd_z_hi = access && !pwrite && hit(paddr, Z_HI_IDX);
  assign rd_stat = access && !pwrite && hit(paddr, STATUS_IDX);
  assign rd_irq = access && !pwrite && hit(paddr, IRQ_STAT_IDX);
  assign hi_read = {rd_z_hi, rd_y_hi, rd_x_hi};

  ////////////////////////////////////////////////////////////////////////
  // Sample store
  // Address alone steers the store; its byte is ready one edge after setup
  logic [7:0] store_byte;
  logic [1:0] rd_axis;
  logic rd_hi;
  always_comb begin
    rd_axis = 2'h3;
    rd_hi = 1'b0;
    if (hit(paddr, X_HI_IDX) || hit(paddr, X_LO_IDX)) rd_axis = 2'h0;
    if (hit(paddr, Y_HI_IDX) || hit(paddr, Y_LO_IDX)) rd_axis = 2'h1;
    if (hit(paddr, Z_HI_IDX) || hit(paddr, Z_LO_IDX)) rd_axis = 2'h2;
    rd_hi = hit(paddr, X_HI_IDX) || hit(paddr, Y_HI_IDX) || hit(paddr, Z_HI_IDX);
  end

  mag_sample_store u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(sample_done), // [R12]
    .wr_data(sample_data),
    .rd_axis(rd_axis),
    .rd_hi(rd_hi),
    .rd_data(store_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // Flags
  logic [2:0] ready_reg, ready_next, ovr_reg, ovr_next;
  logic [2:0] set_seen_reg, set_seen_next, hi_pend_reg, hi_pend_next;
  logic all_ready_reg, all_ready_next, all_ovr_reg, all_ovr_next;
  logic [2:0] read_pend_reg, read_pend_next;
  logic [2:0] seen_now;

  always_comb begin
    // Ready: set wins over a same-cycle clear; overrun: the clear wins
    for (int i = 0; i < AXES; i++) begin
      ready_next[i] = (ready_reg[i] && !hi_read[i]) || sample_done[i]; // [R4] [R6] [R8] [R5] [R7] [R9]
      ovr_next[i] = (ovr_reg[i] && !hi_read[i]) || (sample_done[i] && ready_reg[i] && !hi_read[i]); // [R1] [R10]
    end
    // Axes completed since the last full set
    seen_now = set_seen_reg | sample_done;
    set_seen_next = seen_now;
    // High bytes still unread for the current set
    read_pend_next = read_pend_reg & ~hi_read;
    all_ready_next = all_ready_reg;
    if (all_ready_reg && (read_pend_next == 3'h0)) all_ready_next = 1'b0; // [R3]
    // A new set re-arms the read tracking, even while the flag is still up
    if (&seen_now) begin
      all_ready_next = 1'b1; // [R2]
      read_pend_next = 3'h7;
      set_seen_next = 3'h0;
    end
    // Any axis overwrite re-arms all three pending reads
    hi_pend_next = hi_pend_reg & ~hi_read;
    all_ovr_next = all_ovr_reg;
    if (all_ovr_reg && (hi_pend_next == 3'h0)) all_ovr_next = 1'b0; // [R11]
    if (|(sample_done & ready_reg & ~hi_read)) begin
      all_ovr_next = 1'b1; // [R11]
      hi_pend_next = 3'h7;
    end
    // Writes never reach the flags
  end // [R13]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_reg <= 3'h0;
      ovr_reg <= 3'h0;
      set_seen_reg <= 3'h0;
      hi_pend_reg <= 3'h0;
      read_pend_reg <= 3'h0;
      all_ready_reg <= 1'b0;
      all_ovr_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
      ovr_reg <= ovr_next;
      set_seen_reg <= set_seen_next;
      hi_pend_reg <= hi_pend_next;
      read_pend_reg <= read_pend_next;
      all_ready_reg <= all_ready_next;
      all_ovr_reg <= all_ovr_next;
    end
  end

  logic [7:0] status_now;
  assign status_now = {all_ovr_reg, ovr_reg[2], ovr_reg[1], ovr_reg[0],
                       all_ready_reg, ready_reg[2], ready_reg[1], ready_reg[0]};

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: new data per axis, any overrun
  logic [3:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [3:0] irq_evt;
  assign irq_evt = {|(sample_done & ready_reg), sample_done};
  always_comb begin
    // Clear only the bits handed out, so an event after the setup edge survives
    irq_stat_next = (rd_irq ? (irq_stat_reg & ~prdata[3:0]) : irq_stat_reg) | irq_evt;
    irq_mask_next = irq_mask_reg;
    if (access && pwrite && hit(paddr, IRQ_MASK_IDX)) irq_mask_next = pwdata[3:0];
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer
  logic known, data_sel;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic wait_reg, wait_next;
  assign known = hit(paddr, STATUS_IDX) || (rd_axis != 2'h3) ||
                 hit(paddr, IRQ_STAT_IDX) || hit(paddr, IRQ_MASK_IDX);
  assign data_sel = rd_axis != 2'h3;
  always_comb begin
    // Sample bytes take one wait state: the store's registered byte lands a cycle late
    wait_next = setup && data_sel;
    pready_next = (setup && !data_sel) || wait_reg;
    pslverr_next = setup && !known;
    prdata_next = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (hit(paddr, STATUS_IDX)) prdata_next = {24'h000000, status_now};
      if (hit(paddr, IRQ_STAT_IDX)) prdata_next = {28'h0000000, irq_stat_reg};
      if (hit(paddr, IRQ_MASK_IDX)) prdata_next = {28'h0000000, irq_mask_reg};
    end
    if (wait_reg && !pwrite) prdata_next = {24'h000000, store_byte}; // [R12]
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      wait_reg <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      status_out <= STATUS_RESET;
      irq <= 1'b0;
    end else begin
      pready <= pready_next;
      pslverr <= pslverr_next;
      prdata <= prdata_next;
      wait_reg <= wait_next;
      status_out <= {all_ovr_next, ovr_next, all_ready_next, ready_next};
      irq <= |(irq_stat_next & irq_mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property ready_set_p(int b);
    @(posedge clk) disable iff (sys_rst) sample_done[b] |=> status_out[b];
  endproperty
  x_ready_set_a: assert property (ready_set_p(0)) else $error("x_ready not set"); // [R8]
  y_ready_set_a: assert property (ready_set_p(1)) else $error("y_ready not set"); // [R6]
  z_ready_set_a: assert property (ready_set_p(2)) else $error("z_ready not set"); // [R4]
  x_ready_clr_a: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    rd_x_hi && !sample_done[0] |=> !status_out[0]) else $error("x_ready not cleared");
  y_ready_clr_a: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    rd_y_hi && !sample_done[1] |=> !status_out[1]) else $error("y_ready not cleared");
  z_ready_clr_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    rd_z_hi && !sample_done[2] |=> !status_out[2]) else $error("z_ready not cleared");
  x_ovr_set_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    sample_done[0] && ready_reg[0] && !rd_x_hi |=> status_out[4]) else $error("x_overrun");
  x_ovr_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    !ready_reg[0] && !ovr_reg[0] |=> !ovr_reg[0]) else $error("x_overrun spurious");
  all_ovr_set_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    |(sample_done & ready_reg & ~hi_read) |=> all_ovr_reg) else $error("all_overrun");
  all_rdy_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    all_ready_reg && hi_read == 3'h0 && read_pend_reg != 3'h0 |=> all_ready_reg)
    else $error("all_ready dropped early");
  all_rdy_set_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    &(set_seen_reg | sample_done) |=> all_ready_reg) else $error("all_ready not set");
  no_write_a: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    access && pwrite && sample_done == 3'h0 |=> $stable(status_now))
    else $error("write changed flags");

  ////////////////////////////////////////////////////////////////////////
  // Read side, built from the steps of a high-byte read
  sequence axis_read_s(int b);
    hi_read[b] && !sample_done[b];
  endsequence

  sequence axis_flags_clear_s(int b);
    !status_out[b] && !status_out[b + 4];
  endsequence

  property read_clears_p(int b);
    @(posedge clk) disable iff (sys_rst) axis_read_s(b) |=> axis_flags_clear_s(b);
  endproperty
  x_read_clr_a: assert property (read_clears_p(0)) else $error("x flags not cleared"); // [R10]
  y_read_clr_a: assert property (read_clears_p(1)) else $error("y flags not cleared"); // [R7]
  z_read_clr_a: assert property (read_clears_p(2)) else $error("z flags not cleared"); // [R5]

  // Data flags stand until their high byte is read
  property ready_hold_p(int b);
    @(posedge clk) disable iff (sys_rst) status_out[b] && !hi_read[b] |=> status_out[b];
  endproperty
  x_ready_hold_a: assert property (ready_hold_p(0)) else $error("x_ready lost"); // [R8]
  y_ready_hold_a: assert property (ready_hold_p(1)) else $error("y_ready lost"); // [R6]
  z_ready_hold_a: assert property (ready_hold_p(2)) else $error("z_ready lost"); // [R4]

  // No sample racing a status read means nothing moves
  stat_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_stat && sample_done == 3'h0 |=> $stable(status_now))
    else $error("status read moved flags");

  // Overwrite of unread data on the other two axes
  property ovr_set_p(int b);
    @(posedge clk) disable iff (sys_rst)
      sample_done[b] && ready_reg[b] && !hi_read[b] |=> status_out[b + 4];
  endproperty
  y_ovr_set_a: assert property (ovr_set_p(1)) else $error("y_overrun not set");
  z_ovr_set_a: assert property (ovr_set_p(2)) else $error("z_overrun not set");

  property ovr_quiet_p(int b);
    @(posedge clk) disable iff (sys_rst) !ready_reg[b] && !ovr_reg[b] |=> !ovr_reg[b];
  endproperty
  y_ovr_hold_a: assert property (ovr_quiet_p(1)) else $error("y_overrun spurious");
  z_ovr_hold_a: assert property (ovr_quiet_p(2)) else $error("z_overrun spurious");

  all_ovr_clr_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    all_ovr_reg && hi_read != 3'h0 && hi_pend_reg == hi_read && sample_done == 3'h0
    |=> !all_ovr_reg) else $error("all_overrun not cleared");
  all_rdy_quiet_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    !all_ready_reg && !(&(set_seen_reg | sample_done)) |=> !all_ready_reg)
    else $error("all_ready without a full set");

  ////////////////////////////////////////////////////////////////////////
  // Bus answer shape
  sequence sample_wait_s;
    !pready ##1 pready;
  endsequence
  data_wait_a: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    setup && data_sel |=> sample_wait_s) else $error("sample byte wait state wrong");
  ready_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready |=> !pready) else $error("pready held");
  err_with_rdy_a: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    setup && !known |=> pready && pslverr) else $error("unmapped address accepted");
  known_ok_a: assert property (@(posedge clk) disable iff (sys_rst)
    setup && known |=> !pslverr) else $error("mapped address refused");
  status_wr_ok_a: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    setup && pwrite && hit(paddr, STATUS_IDX) |=> pready && !pslverr)
    else $error("status write refused");

  // Events stick until an interrupt status read hands them out
  for (genvar g = 0; g < IRQ_BITS; g++) begin : g_irq_chk
    irq_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
      irq_evt[g] |=> irq_stat_reg[g]) else $error("interrupt event lost");
    irq_raise_a: assert property (@(posedge clk) disable iff (sys_rst)
      irq_evt[g] && irq_mask_reg[g] && !(access && pwrite && hit(paddr, IRQ_MASK_IDX))
      |=> irq) else $error("unmasked event did not raise irq");
  end
endmodule : mag_ready_status

// File: testbench/mag_ready_status_tb.sv
`timescale 1ns/10ps
module mag_ready_status_tb;
  import mag_status_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] sample_done = 3'h0;
  logic [47:0] sample_data = 48'h000000000000;
  logic [7:0] status_out;
  logic irq;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int n_compared = 0;

  mag_ready_status dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_done(sample_done), .sample_data(sample_data),
    .status_out(status_out), .irq(irq));

  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits on pready, the watchdog bounds the wait
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Status byte seen both on the mirror and over the bus
  task automatic st(input logic [7:0] exp);
    @(posedge clk);
    chk({24'h000000, status_out}, {24'h000000, exp});
    xfer(STATUS_IDX, 1'b0, 32'h00000000);
    chk(rd, {24'h000000, exp});
  endtask : st

  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    sample_done <= m;
    sample_data <= 48'h8001_7FFF_1234;
    @(posedge clk);
    sample_done <= 3'h0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic rst;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : rst

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    st(8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    for (int a = 0; a < AXES; a++) begin
      rst();
      pulse(3'h1 << a);
      st(8'h01 << a);
      xfer(X_HI_IDX + 8'(2 * a), 1'b0, 32'h0);
      st(8'h00);
      // Two samples without a read in between
      pulse(3'h1 << a);
      pulse(3'h1 << a);
      st((8'h11 << a) | 8'h80);
      xfer(X_HI_IDX + 8'(2 * a), 1'b0, 32'h0);
      st(8'h80);
      for (int b = 0; b < AXES; b++) xfer(X_HI_IDX + 8'(2 * b), 1'b0, 32'h0);
      st(8'h00);
    end
    $display("test per-axis done");
    rst();
    pulse(3'h7);
    st(8'h0F);
    xfer(X_HI_IDX, 1'b0, 32'h0);
    chk(rd, 32'h00000012);
    st(8'h0E);
    xfer(Y_HI_IDX, 1'b0, 32'h0);
    chk(rd, 32'h0000007F);
    st(8'h0C);
    xfer(Z_HI_IDX, 1'b0, 32'h0);
    chk(rd, 32'h00000080);
    st(8'h00);
    $display("test all-axes done");
    rst();
    pulse(3'h1);
    xfer(STATUS_IDX, 1'b1, 32'h000000FF);
    chk({31'h0, err}, 32'h0);
    st(8'h01);
    xfer(X_LO_IDX, 1'b0, 32'h0);
    chk(rd, 32'h00000034);
    st(8'h01);
    xfer(8'h20, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test access done");
    rst();
    xfer(IRQ_MASK_IDX, 1'b1, 32'h00000001);
    xfer(IRQ_MASK_IDX, 1'b0, 32'h0);
    chk(rd, 32'h00000001);
    pulse(3'h2);
    chk({31'h0, irq}, 32'h0);
    pulse(3'h1);
    chk({31'h0, irq}, 32'h1);
    xfer(IRQ_STAT_IDX, 1'b0, 32'h0);
    chk(rd, 32'h00000003);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    xfer(Y_HI_IDX, 1'b0, 32'h0);
    xfer(IRQ_MASK_IDX, 1'b1, 32'h00000008);
    pulse(3'h2);
    chk({31'h0, irq}, 32'h0);
    pulse(3'h2);
    chk({31'h0, irq}, 32'h1);
    xfer(IRQ_STAT_IDX, 1'b0, 32'h0);
    chk(rd, 32'h0000000A);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : mag_ready_status_tb
